// [core/lcdc_device.sv]
`timescale 1ns/1ns
`include "lcdc_consts.svh"
module lcdc_device #(
    parameter int PAGES = 16,
    parameter int COLS = 160,
    parameter int INIT_CYCLES = `LCDC_INIT_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    lcdc_bus_if.dev bus,
    input wire logic [2:0] makerIdStrap,
    input wire logic [1:0] panelSizeStrap,
    input wire logic [3:0] scanPage,
    input wire logic [7:0] scanCol,
    output logic [7:0] scanData,
    output logic displayOn,
    output logic [3:0] vertical_rate_code,
    output logic [7:0] frameRateHz,
    output logic booster_level_select,
    output logic instruction_page_select,
    output logic [6:0] start_line_bits
);
    localparam int AW = $clog2(PAGES * COLS);

    if (PAGES < 1 || PAGES > 16 || COLS < 2 || COLS > 256 || INIT_CYCLES < 1
        || INIT_CYCLES > 65535) begin : g_chk
        $error("lcdc_device: unsupported geometry or init count");
    end

    // Frame frequency in Hz for each rate code, full-panel display
    localparam logic [7:0] RATE_HZ [16] = '{8'h4d, 8'h33, 8'h37, 8'h3a, 8'h3f, 8'h43, 8'h44,
        8'h46, 8'h49, 8'h4b, 8'h50, 8'h55, 8'h5b, 8'h66, 8'h71, 8'h7b};

    function automatic logic [AW-1:0] ramIndex(input logic [3:0] pg, input logic [7:0] col);
        ramIndex = AW'(int'(pg) * COLS + int'(col));
    endfunction : ramIndex

    function automatic logic [7:0] colNext(input logic [7:0] col);
        colNext = (int'(col) >= COLS - 1) ? 8'h00 : 8'(col + 8'h01);
    endfunction : colNext

    logic [7:0] ram [PAGES * COLS];
    lcdc_pkg::lcdc_dec_t dec_ff, nxt_dec;
    logic [15:0] initCnt_ff, nxt_initCnt;
    logic [3:0] page_ff, nxt_page;
    logic [7:0] col_ff, nxt_col, savedCol_ff, nxt_savedCol;
    logic modRead_ff, nxt_modRead;
    logic [7:0] readLatch_ff, nxt_readLatch;
    logic ack_ff, nxt_ack;
    logic [7:0] devData_ff, nxt_devData;
    logic devDataOe_ff, nxt_devDataOe;
    logic on_ff, nxt_on;
    logic [3:0] rate_ff, nxt_rate;
    logic [7:0] rateHz_ff, nxt_rateHz;
    logic boost_ff, nxt_boost;
    logic xpage_ff, nxt_xpage;
    logic [6:0] line_ff, nxt_line;
    logic [7:0] scan_ff, nxt_scan;
    logic [2:0] makerMeta_ff, makerSync_ff, maker_ff, nxt_maker;
    logic [1:0] sizeMeta_ff, sizeSync_ff, size_ff, nxt_size;
    logic [3:0] scanPgMeta_ff, scanPg_ff;
    logic [7:0] scanColMeta_ff, scanCol_ff;
    logic initActive;
    logic ramWe;
    logic [7:0] b;

    // Byte decoder, address pointers and mode state
    always_comb begin
        nxt_dec = dec_ff;
        nxt_initCnt = initCnt_ff;
        nxt_page = page_ff;
        nxt_col = col_ff;
        nxt_savedCol = savedCol_ff;
        nxt_modRead = modRead_ff;
        nxt_readLatch = readLatch_ff;
        nxt_ack = 1'b0;
        nxt_devData = 8'h00;
        nxt_devDataOe = 1'b0;
        nxt_on = on_ff;
        nxt_rate = rate_ff;
        nxt_boost = boost_ff;
        nxt_xpage = xpage_ff;
        nxt_line = line_ff;
        nxt_maker = maker_ff;
        nxt_size = size_ff;
        ramWe = 1'b0;
        b = bus.dataBus;
        initActive = (initCnt_ff != 16'h0000);
        // Straps are taken while init runs, never from host writes
        if (initActive) begin
            nxt_initCnt = 16'(initCnt_ff - 16'h0001);
            nxt_maker = makerSync_ff;
            nxt_size = sizeSync_ff;
        end
        nxt_rateHz = RATE_HZ[rate_ff];
        nxt_scan = ram[ramIndex(scanPg_ff, scanCol_ff)];
        if (bus.strobe) begin
            nxt_ack = 1'b1;
            if (!bus.cmdDataSel && bus.transferDir) begin
                // Status read is always answered
                nxt_devDataOe = 1'b1;
                nxt_devData[`LCDC_ST_BUSY] = initActive;
                nxt_devData[`LCDC_ST_ON] = on_ff;
                nxt_devData[`LCDC_ST_INIT] = initActive;
                nxt_devData[4:0] = {maker_ff, size_ff};
            end else if (initActive) begin
                nxt_devDataOe = bus.transferDir;
            end else if (bus.cmdDataSel && bus.transferDir) begin
                // Pipelined read: answer latched byte, prefetch current one
                nxt_devDataOe = 1'b1;
                nxt_devData = readLatch_ff;
                nxt_readLatch = ram[ramIndex(page_ff, col_ff)];
                if (!modRead_ff) begin
                    nxt_col = colNext(col_ff);
                end
            end else if (bus.cmdDataSel) begin
                ramWe = 1'b1;
                nxt_col = colNext(col_ff);
            end else begin
                unique case (dec_ff)
                    lcdc_pkg::DEC_MODE: begin
                        nxt_rate = b[`LCDC_MODE_RATE];
                        nxt_boost = b[`LCDC_MODE_BOOST];
                        nxt_xpage = b[`LCDC_MODE_PAGE];
                        nxt_dec = lcdc_pkg::DEC_FIRST;
                    end
                    lcdc_pkg::DEC_LINE: begin
                        nxt_line = b[`LCDC_LINE_FIELD];
                        nxt_dec = lcdc_pkg::DEC_FIRST;
                    end
                    lcdc_pkg::DEC_FIRST: begin
                        if (b == `LCDC_OP_MODE) begin
                            nxt_dec = lcdc_pkg::DEC_MODE;
                        end else if (!xpage_ff) begin
                            if (b[7:4] == `LCDC_OP_PAGE_HI) begin
                                nxt_page = b[3:0];
                            end else if (b[7:4] == `LCDC_OP_COLMSB_HI) begin
                                nxt_col = {b[3:0], col_ff[3:0]};
                            end else if (b[7:4] == `LCDC_OP_COLLSB_HI) begin
                                nxt_col = {col_ff[7:4], b[3:0]};
                            end else if (b == `LCDC_OP_MODRD_SET) begin
                                nxt_modRead = 1'b1;
                                nxt_savedCol = col_ff;
                            end else if (b == `LCDC_OP_MODRD_CLR) begin
                                nxt_modRead = 1'b0;
                                nxt_col = savedCol_ff;
                            end else if (b[7:1] == `LCDC_OP_DISP_HI) begin
                                nxt_on = b[0];
                            end else if (b[7:2] == `LCDC_OP_LINE_HI) begin
                                nxt_dec = lcdc_pkg::DEC_LINE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Decoder and pointer registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dec_ff <= lcdc_pkg::DEC_FIRST;
            initCnt_ff <= 16'(INIT_CYCLES);
            page_ff <= 4'h0;
            col_ff <= 8'h00;
            savedCol_ff <= 8'h00;
            modRead_ff <= 1'b0;
            readLatch_ff <= 8'h00;
            ack_ff <= 1'b0;
            devData_ff <= 8'h00;
            devDataOe_ff <= 1'b0;
            on_ff <= `LCDC_ON_RST;
            rate_ff <= `LCDC_RATE_RST;
            rateHz_ff <= 8'h00;
            boost_ff <= `LCDC_BOOST_RST;
            xpage_ff <= `LCDC_XPAGE_RST;
            line_ff <= 7'h00;
            scan_ff <= 8'h00;
            maker_ff <= `LCDC_MAKER_RST;
            size_ff <= `LCDC_SIZE_RST;
        end else begin
            dec_ff <= nxt_dec;
            initCnt_ff <= nxt_initCnt;
            page_ff <= nxt_page;
            col_ff <= nxt_col;
            savedCol_ff <= nxt_savedCol;
            modRead_ff <= nxt_modRead;
            readLatch_ff <= nxt_readLatch;
            ack_ff <= nxt_ack;
            devData_ff <= nxt_devData;
            devDataOe_ff <= nxt_devDataOe;
            on_ff <= nxt_on;
            rate_ff <= nxt_rate;
            rateHz_ff <= nxt_rateHz;
            boost_ff <= nxt_boost;
            xpage_ff <= nxt_xpage;
            line_ff <= nxt_line;
            scan_ff <= nxt_scan;
            maker_ff <= nxt_maker;
            size_ff <= nxt_size;
        end
    end

    // Two-stage synchronisers for strap and panel scan pins
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            makerMeta_ff <= 3'h0;
            makerSync_ff <= 3'h0;
            sizeMeta_ff <= 2'h0;
            sizeSync_ff <= 2'h0;
            scanPgMeta_ff <= 4'h0;
            scanPg_ff <= 4'h0;
            scanColMeta_ff <= 8'h00;
            scanCol_ff <= 8'h00;
        end else begin
            makerMeta_ff <= makerIdStrap;
            makerSync_ff <= makerMeta_ff;
            sizeMeta_ff <= panelSizeStrap;
            sizeSync_ff <= sizeMeta_ff;
            scanPgMeta_ff <= scanPage;
            scanPg_ff <= scanPgMeta_ff;
            scanColMeta_ff <= scanCol;
            scanCol_ff <= scanColMeta_ff;
        end
    end

    // Display RAM write port
    always_ff @(posedge mclk) begin
        if (ramWe) begin
            ram[ramIndex(page_ff, col_ff)] <= bus.dataBus;
        end
    end

    assign bus.ack = ack_ff;
    assign bus.devData = devData_ff;
    assign bus.devDataOe = devDataOe_ff;
    assign scanData = scan_ff;
    assign displayOn = on_ff;
    assign vertical_rate_code = rate_ff;
    assign frameRateHz = rateHz_ff;
    assign booster_level_select = boost_ff;
    assign instruction_page_select = xpage_ff;
    assign start_line_bits = line_ff;
endmodule : lcdc_device

// [core/lcdc_consts.svh]
// Overview of operation
// - Mode second byte: rate, zero, booster, page
// - Rate code maps to frame frequency table
// - Booster select picks level; resets level 2
// - Page select 0 base set, 1 extended
// - Data read returns byte, column advances
// - Host dummy-reads after column address load
// - RAM readable only over parallel port
// - Data write stores byte, column advances, wraps
// - Status byte: busy, on, init, maker, size
// - Busy rejects instructions; host waits idle
// - Display-on status bit follows display state
// - Init flag high while reset init runs
// - Maker and size fields come from straps
// - Page command 1011 with 4-bit page
// - Page change leaves panel view untouched
// - Column from two nibble commands, 0..159
// - Modify-read entry stops read increment only
// - Modify-read exit restores saved column
// - Display on/off command with on bit
// - Display off still executes commands
// - Two-byte command sets top display line
// - Line command 010000xx then 7-bit line
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH

// Instruction codes
`define LCDC_OP_MODE 8'h38
`define LCDC_OP_PAGE_HI 4'hb
`define LCDC_OP_COLMSB_HI 4'h1
`define LCDC_OP_COLLSB_HI 4'h0
`define LCDC_OP_MODRD_SET 8'he0
`define LCDC_OP_MODRD_CLR 8'hee
`define LCDC_OP_DISP_HI 7'h57
`define LCDC_OP_LINE_HI 6'h10

// Mode byte fields
`define LCDC_MODE_RATE 7:4
`define LCDC_MODE_ZERO 3
`define LCDC_MODE_BOOST 2
`define LCDC_MODE_PAGE 0
`define LCDC_LINE_FIELD 6:0

// Status byte fields
`define LCDC_ST_BUSY 7
`define LCDC_ST_ON 6
`define LCDC_ST_INIT 5

// Reset values
`define LCDC_RATE_RST 4'h0
`define LCDC_BOOST_RST 1'b1
`define LCDC_XPAGE_RST 1'b0
`define LCDC_ON_RST 1'b0
`define LCDC_MAKER_RST 3'h0
`define LCDC_SIZE_RST 2'h0

// Init time after reset
`define LCDC_CLK_NS 4
`define LCDC_INIT_NS 1000
`define LCDC_INIT_CYC ((`LCDC_INIT_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)

// Host register map and fields
`define LCDC_HREG_CMD 4'h0
`define LCDC_HREG_STAT 4'h4
`define LCDC_HCMD_SEL 8
`define LCDC_HCMD_READ 9
`define LCDC_HSTAT_BUSY 31
`define LCDC_HSTAT_DUMMY 30

`endif

// [core/lcdc_pkg.sv]
package lcdc_pkg;
    // Device byte decoder state
    typedef enum logic [2:0] {
        DEC_FIRST = 3'b001,
        DEC_MODE = 3'b010,
        DEC_LINE = 3'b100
    } lcdc_dec_t;

    // Host transfer engine state
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_POLL = 5'b00010,
        H_POLLW = 5'b00100,
        H_XFER = 5'b01000,
        H_XFERW = 5'b10000
    } lcdc_host_t;
endpackage : lcdc_pkg

// [core/lcdc_bus_if.sv]
`timescale 1ns/1ns
interface lcdc_bus_if;
    logic strobe;
    logic cmdDataSel;
    logic transferDir;
    logic [7:0] hostData;
    logic hostDataOe;
    logic ack;
    logic [7:0] devData;
    logic devDataOe;
    logic [7:0] dataBus;

    // Shared byte lines, pulled high when nobody drives
    assign dataBus = hostDataOe ? hostData : (devDataOe ? devData : 8'hff);

    modport dev (
        input strobe, cmdDataSel, transferDir, dataBus,
        output ack, devData, devDataOe
    );
    modport host (
        output strobe, cmdDataSel, transferDir, hostData, hostDataOe,
        input ack, dataBus
    );
endinterface : lcdc_bus_if

// [core/lcdc_host.sv]
`timescale 1ns/1ns
`include "lcdc_consts.svh"
module lcdc_host (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    lcdc_bus_if.host bus
);
    lcdc_pkg::lcdc_host_t st_ff, nxt_st;
    logic [7:0] pByte_ff, nxt_pByte;
    logic pSel_ff, nxt_pSel, pRead_ff, nxt_pRead;
    logic needDummy_ff, nxt_needDummy, isDummy_ff, nxt_isDummy;
    logic [7:0] result_ff, nxt_result;
    logic strobe_ff, nxt_strobe, sel_ff, nxt_sel, dir_ff, nxt_dir;
    logic [7:0] data_ff, nxt_data;
    logic oe_ff, nxt_oe;
    logic wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    logic busReq;

    // Avalon slave and transfer engine
    always_comb begin
        nxt_st = st_ff;
        nxt_pByte = pByte_ff;
        nxt_pSel = pSel_ff;
        nxt_pRead = pRead_ff;
        nxt_needDummy = needDummy_ff;
        nxt_isDummy = isDummy_ff;
        nxt_result = result_ff;
        nxt_strobe = 1'b0;
        nxt_sel = sel_ff;
        nxt_dir = dir_ff;
        nxt_data = data_ff;
        nxt_oe = oe_ff;
        nxt_wait = 1'b1;
        nxt_rdata = 32'h0000_0000;
        busReq = (avs_read || avs_write) && wait_ff;
        // Answer one cycle after the request; command writes wait for idle
        if (busReq && avs_read) begin
            nxt_wait = 1'b0;
            if (avs_address == `LCDC_HREG_STAT) begin
                nxt_rdata[`LCDC_HSTAT_BUSY] = (st_ff != lcdc_pkg::H_IDLE);
                nxt_rdata[`LCDC_HSTAT_DUMMY] = needDummy_ff;
                nxt_rdata[7:0] = result_ff;
            end
        end else if (busReq && (avs_address != `LCDC_HREG_CMD)) begin
            nxt_wait = 1'b0;
        end else if (busReq && st_ff == lcdc_pkg::H_IDLE) begin
            nxt_wait = 1'b0;
            nxt_pByte = avs_writedata[7:0];
            nxt_pSel = avs_writedata[`LCDC_HCMD_SEL];
            nxt_pRead = avs_writedata[`LCDC_HCMD_READ];
            nxt_isDummy = 1'b0;
            // Status reads skip the busy poll
            if (!avs_writedata[`LCDC_HCMD_SEL] && avs_writedata[`LCDC_HCMD_READ]) begin
                nxt_st = lcdc_pkg::H_XFER;
            end else begin
                nxt_st = lcdc_pkg::H_POLL;
            end
        end
        unique case (st_ff)
            lcdc_pkg::H_IDLE: begin
                nxt_oe = 1'b0;
            end
            lcdc_pkg::H_POLL: begin
                nxt_strobe = 1'b1;
                nxt_sel = 1'b0;
                nxt_dir = 1'b1;
                nxt_oe = 1'b0;
                nxt_st = lcdc_pkg::H_POLLW;
            end
            lcdc_pkg::H_POLLW: begin
                if (bus.ack) begin
                    nxt_st = bus.dataBus[`LCDC_ST_BUSY] ? lcdc_pkg::H_POLL
                                                        : lcdc_pkg::H_XFER;
                end
            end
            lcdc_pkg::H_XFER: begin
                nxt_strobe = 1'b1;
                nxt_sel = pSel_ff;
                nxt_dir = pRead_ff;
                nxt_data = pByte_ff;
                nxt_oe = !pRead_ff;
                nxt_isDummy = pSel_ff && pRead_ff && needDummy_ff;
                nxt_st = lcdc_pkg::H_XFERW;
            end
            lcdc_pkg::H_XFERW: begin
                if (bus.ack) begin
                    nxt_oe = 1'b0;
                    nxt_st = lcdc_pkg::H_IDLE;
                    if (isDummy_ff) begin
                        nxt_needDummy = 1'b0;
                        nxt_isDummy = 1'b0;
                        nxt_st = lcdc_pkg::H_POLL;
                    end else if (pRead_ff) begin
                        nxt_result = bus.dataBus;
                    end else if (!pSel_ff && (pByte_ff[7:5] == 3'h0)) begin
                        nxt_needDummy = 1'b1;
                    end
                end
            end
        endcase
    end

    // Engine and bus registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= lcdc_pkg::H_IDLE;
            pByte_ff <= 8'h00;
            pSel_ff <= 1'b0;
            pRead_ff <= 1'b0;
            needDummy_ff <= 1'b1;
            isDummy_ff <= 1'b0;
            result_ff <= 8'h00;
            strobe_ff <= 1'b0;
            sel_ff <= 1'b0;
            dir_ff <= 1'b0;
            data_ff <= 8'h00;
            oe_ff <= 1'b0;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
            pByte_ff <= nxt_pByte;
            pSel_ff <= nxt_pSel;
            pRead_ff <= nxt_pRead;
            needDummy_ff <= nxt_needDummy;
            isDummy_ff <= nxt_isDummy;
            result_ff <= nxt_result;
            strobe_ff <= nxt_strobe;
            sel_ff <= nxt_sel;
            dir_ff <= nxt_dir;
            data_ff <= nxt_data;
            oe_ff <= nxt_oe;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign bus.strobe = strobe_ff;
    assign bus.cmdDataSel = sel_ff;
    assign bus.transferDir = dir_ff;
    assign bus.hostData = data_ff;
    assign bus.hostDataOe = oe_ff;
endmodule : lcdc_host

// [sim/lcdc_link_asserts.sv]
`timescale 1ns/1ns
module lcdc_link_asserts #(
    parameter logic [2:0] MAKER = 3'h5, // Arbitrary strap value
    parameter logic [1:0] SIZE = 2'h1, // Arbitrary strap value
    parameter int INIT_CYCLES = 250
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic strobe,
    input wire logic cmdDataSel,
    input wire logic transferDir,
    input wire logic [7:0] hostData,
    input wire logic hostDataOe,
    input wire logic ack,
    input wire logic [7:0] devData,
    input wire logic devDataOe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    int sinceRst_ff, nxt_sinceRst;
    logic initExp;
    // Edges since reset release, saturating at the init length
    always_comb begin
        nxt_sinceRst = sinceRst_ff;
        if (sinceRst_ff < INIT_CYCLES) begin
            nxt_sinceRst = sinceRst_ff + 1;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sinceRst_ff <= 0;
        end else begin
            sinceRst_ff <= nxt_sinceRst;
        end
    end
    // Init still running at this edge, reckoned independently of the device
    assign initExp = (sinceRst_ff < INIT_CYCLES);
    // Status request on the link
    sequence stReq;
        strobe && !cmdDataSel && transferDir;
    endsequence
    // Link handshake and byte lane ownership
    a_ack_follows_strobe: assert property (strobe |=> ack)
        else $error("ack missing after strobe");
    a_ack_needs_strobe: assert property (ack |-> $past(strobe))
        else $error("ack without strobe");
    a_strobe_one_cycle: assert property (strobe |=> !strobe)
        else $error("strobe longer than one cycle");
    a_dev_drives_reads: assert property (devDataOe |-> ack && !hostDataOe)
        else $error("device drives outside read answer");
    a_host_holds_byte: assert property (strobe && hostDataOe |=> hostDataOe && $stable(hostData))
        else $error("host byte not held to ack");
    a_write_lane_owned: assert property (strobe && !transferDir |-> hostDataOe)
        else $error("write without host drive");
    a_read_lane_free: assert property (strobe && transferDir |-> !hostDataOe ##1 devDataOe)
        else $error("read lane ownership wrong");
    // Status byte content
    a_busy_is_init: assert property (stReq |=> devData[7] == $past(initExp)
        && devData[5] == $past(initExp)) else $error("busy or init flag off schedule");
    a_strap_fields: assert property (stReq ##1 !devData[7] |-> devData[4:0] == {MAKER, SIZE})
        else $error("status id fields differ from straps");
    c_status: cover property (stReq ##1 !devData[7]);
    c_data_read: cover property (strobe && cmdDataSel && transferDir);
    c_data_write: cover property (strobe && cmdDataSel && !transferDir);
endmodule : lcdc_link_asserts

// [sim/tb.sv]
`timescale 1ns/1ns
`include "lcdc_consts.svh"
module tb;
    localparam logic [2:0] MAKER = 3'h5; // Arbitrary strap value
    localparam logic [1:0] SIZE = 2'h1; // Arbitrary strap value
    localparam int INIT = 40; // Short init, long enough to see busy from the host
    localparam int HZ[16] = '{77, 51, 55, 58, 63, 67, 68, 70, 73, 75, 80, 85, 91, 102, 113, 123};
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [3:0] scanPage = 4'h0;
    logic [7:0] scanCol = 8'h00;
    logic [7:0] scanData;
    logic displayOn;
    logic [3:0] rateCode;
    logic [7:0] frameRateHz;
    logic boost;
    logic xpage;
    logic [6:0] line;
    logic [31:0] q;
    int n_errors = 0;
    int total_checks = 0;
    lcdc_bus_if bus ();
    lcdc_host lcdc_host_inst (.mclk(mclk), .rstn(rstn), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .bus(bus));
    lcdc_device #(.INIT_CYCLES(INIT)) lcdc_device_inst (.mclk(mclk), .rstn(rstn), .bus(bus),
        .makerIdStrap(MAKER), .panelSizeStrap(SIZE), .scanPage(scanPage), .scanCol(scanCol),
        .scanData(scanData), .displayOn(displayOn), .vertical_rate_code(rateCode),
        .frameRateHz(frameRateHz), .booster_level_select(boost),
        .instruction_page_select(xpage), .start_line_bits(line));
    lcdc_link_asserts #(.MAKER(MAKER), .SIZE(SIZE), .INIT_CYCLES(INIT)) lcdc_link_asserts_inst (
        .mclk(mclk), .rstn(rstn), .strobe(bus.strobe), .cmdDataSel(bus.cmdDataSel),
        .transferDir(bus.transferDir), .hostData(bus.hostData), .hostDataOe(bus.hostDataOe),
        .ack(bus.ack), .devData(bus.devData), .devDataOe(bus.devDataOe));
    // Clock at 250 MHz
    always #2 mclk = ~mclk;
    // Result compare
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is seen low
    task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge mclk);
        while (avsWaitrequest !== 1'b0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 300) n_errors++;
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : av
    // Link byte through the host engine, then poll until the engine is idle
    task automatic cmd(input logic [7:0] b, input logic sel, input logic rd);
        int n;
        av(`LCDC_HREG_CMD, 1'b1, {22'h0, rd, sel, b});
        n = 0;
        do begin
            av(`LCDC_HREG_STAT, 1'b0, 32'h0);
            n++;
        end while (q[`LCDC_HSTAT_BUSY] !== 1'b0 && n < 100);
        if (n >= 100) n_errors++;
    endtask : cmd
    // Panel side read of one RAM byte
    task automatic scan(input logic [3:0] p, input logic [7:0] c, input logic [7:0] e);
        @(posedge mclk);
        scanPage <= p;
        scanCol <= c;
        repeat (5) @(posedge mclk);
        chk("scanData", e, scanData);
    endtask : scan
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // Watchdog
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    // Test sequence
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk("boost", 1, boost);
        chk("xpage", 0, xpage);
        cmd(8'h00, 1'b0, 1'b1);
        chk("initstat", 3'b101, q[7:5]);
        cmd(8'haf, 1'b0, 1'b0);
        chk("on", 1, displayOn);
        cmd(8'h00, 1'b0, 1'b1);
        chk("status", {24'h0, 3'b010, MAKER, SIZE}, q[7:0]);
        $display("test status done");
        for (int i = 0; i < 16; i++) begin
            cmd(`LCDC_OP_MODE, 1'b0, 1'b0);
            cmd({i[3:0], 1'b0, i[0], 2'b10}, 1'b0, 1'b0);
            chk("rate", i[3:0], rateCode);
            chk("hz", HZ[i], frameRateHz);
            chk("boost", i[0], boost);
        end
        $display("test mode done");
        cmd(`LCDC_OP_MODE, 1'b0, 1'b0);
        cmd(8'h01, 1'b0, 1'b0);
        chk("xpage", 1, xpage);
        cmd(8'hae, 1'b0, 1'b0);
        chk("on", 1, displayOn);
        cmd(`LCDC_OP_MODE, 1'b0, 1'b0);
        cmd(8'h04, 1'b0, 1'b0);
        chk("xpage", 0, xpage);
        $display("test extended done");
        cmd(8'hb3, 1'b0, 1'b0);
        cmd(8'h19, 1'b0, 1'b0);
        cmd(8'h0e, 1'b0, 1'b0);
        cmd(8'haa, 1'b1, 1'b0);
        cmd(8'hbb, 1'b1, 1'b0);
        cmd(8'hcc, 1'b1, 1'b0);
        scan(4'h3, 8'd158, 8'haa);
        scan(4'h3, 8'd159, 8'hbb);
        scan(4'h3, 8'd0, 8'hcc);
        cmd(8'hb5, 1'b0, 1'b0);
        scan(4'h3, 8'd158, 8'haa);
        cmd(8'hb3, 1'b0, 1'b0);
        cmd(8'h19, 1'b0, 1'b0);
        cmd(8'h0e, 1'b0, 1'b0);
        cmd(8'h00, 1'b1, 1'b1);
        chk("read0", 8'haa, q[7:0]);
        cmd(8'h00, 1'b1, 1'b1);
        chk("read1", 8'hbb, q[7:0]);
        cmd(8'h00, 1'b1, 1'b1);
        chk("read2", 8'hcc, q[7:0]);
        $display("test ram done");
        cmd(8'h19, 1'b0, 1'b0);
        cmd(8'h0e, 1'b0, 1'b0);
        cmd(`LCDC_OP_MODRD_SET, 1'b0, 1'b0);
        cmd(8'h00, 1'b1, 1'b1);
        chk("mread0", 8'haa, q[7:0]);
        cmd(8'h00, 1'b1, 1'b1);
        chk("mread1", 8'haa, q[7:0]);
        cmd(8'h5a, 1'b1, 1'b0);
        scan(4'h3, 8'd158, 8'h5a);
        cmd(`LCDC_OP_MODRD_CLR, 1'b0, 1'b0);
        cmd(8'h66, 1'b1, 1'b0);
        scan(4'h3, 8'd158, 8'h66);
        scan(4'h3, 8'd159, 8'hbb);
        $display("test modify done");
        cmd(8'h40, 1'b0, 1'b0);
        cmd(8'h7f, 1'b0, 1'b0);
        chk("line", 7'h7f, line);
        cmd(8'h43, 1'b0, 1'b0);
        cmd(8'h85, 1'b0, 1'b0);
        chk("line", 7'h05, line);
        $display("test line done");
        cmd(8'hae, 1'b0, 1'b0);
        chk("on", 0, displayOn);
        cmd(8'h00, 1'b0, 1'b1);
        chk("status", {24'h0, 3'b000, MAKER, SIZE}, q[7:0]);
        cmd(8'h10, 1'b0, 1'b0);
        cmd(8'h00, 1'b0, 1'b0);
        cmd(8'h77, 1'b1, 1'b0);
        scan(4'h3, 8'd0, 8'h77);
        $display("test off done");
        av(4'h8, 1'b1, 32'hffff);
        av(4'h8, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test unmapped done");
        conclude();
    end
endmodule : tb
